// ### pfc_pkg.sv
// What this block does
// - zero-current level sets above 1.5 V and clears below 1.4 V.
// - gate turns on at the falling edge of the zero-current level.
// - gate forced on after 150 us off without a valid event, startup too.
// - zero-current edges within 3.3 us of gate rise are ignored.
// - gate stays on until the ramp meets the error level or over-current, then off.
// - no gate switching while the error level is below 1.0 V.
// - after supply start, reference climbs in steps over 5 ms.
// - proportional control at startup, then 30 ms hand-over to compensator.
// - absent AC input resets soft-start and holds it until input returns.
// - over-current signal raised while current sense exceeds 0.8 V.
// - gate disabled above 2.675 V feedback, re-enabled 0.175 V lower.
// - operation disabled below 0.35 V feedback, 100 mV hysteresis.
// - operation enabled above 12 V supply, kept until 8.5 V.
`default_nettype none
package pfc_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int RESTART_NS    = 150000;     // 150 us
   localparam int BLANK_NS      = 3300;       // 3.3 us
   localparam int SOFTSTART_NS  = 5000000;    // 5 ms
   localparam int HANDOVER_NS   = 30000000;   // 30 ms
   localparam int STEP_N        = 16;         // stair steps per ramp
   // least times round up
   localparam int RESTART_CYC   =
      (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_CYC     =
      (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // durations spread over the steps, rounded down
   localparam int SS_STEP_CYC   = SOFTSTART_NS / CLK_PERIOD_NS / STEP_N;
   localparam int HO_STEP_CYC   = HANDOVER_NS / CLK_PERIOD_NS / STEP_N;
   localparam int CNT_W         = 20;
   localparam int STEP_W        = 4;
   localparam logic [STEP_W-1:0] STEP_MAX = 4'hF;

   // ---------------------------------------------------------------
   // comparator pin indices
   // ---------------------------------------------------------------
   localparam int PIN_N        = 13;
   localparam int P_ZC_HI      = 0;  // above 1.5 V
   localparam int P_ZC_LO      = 1;  // above 1.4 V
   localparam int P_FB_OV      = 2;  // above 2.675 V
   localparam int P_FB_OV_REL  = 3;  // above 2.5 V
   localparam int P_FB_DIS     = 4;  // above 0.35 V
   localparam int P_FB_DIS_REL = 5;  // above 0.45 V
   localparam int P_VCC_START  = 6;  // above 12 V
   localparam int P_VCC_STOP   = 7;  // above 8.5 V
   localparam int P_COMP_MIN   = 8;  // error level above 1.0 V
   localparam int P_RAMP_MEET  = 9;  // ramp reached error level
   localparam int P_CS_LIM     = 10; // current sense above 0.8 V
   localparam int P_AC_ABSENT  = 11;
   localparam int P_OUT_RATED  = 12;

   // ---------------------------------------------------------------
   // register port
   // ---------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h4;
   localparam logic [ADDR_W-1:0] REG_STEPS  = 4'h8;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   localparam int CTRL_SW_DISABLE = 0;
   localparam int ST_GATE     = 0;
   localparam int ST_VCC_ON   = 1;
   localparam int ST_OV       = 2;
   localparam int ST_FB_DIS   = 3;
   localparam int ST_OCP      = 4;
   localparam int ST_COMP_LOW = 5;
   localparam int ST_AC_ABS   = 6;
   localparam int ST_EXT_COMP = 7;

   typedef enum logic [2:0] {
      SS_IDLE, SS_RAMP, SS_PROP, SS_BLEND, SS_EXT
   } ss_state_t;
   typedef enum logic {G_OFF, G_ON} gate_state_t;
endpackage
`default_nettype wire

// ### cond_if.sv
`default_nettype none
// conditioned comparator levels passed to the sequencer
interface cond_if;
   logic zc_level;
   logic ov_trip;
   logic fb_disabled;
   logic vcc_on;
   logic comp_low;
   logic ramp_meet;
   logic ocp;
   logic ac_absent;
   logic out_rated;
   modport prod (output zc_level, ov_trip, fb_disabled, vcc_on,
                 comp_low, ramp_meet, ocp, ac_absent, out_rated);
   modport cons (input zc_level, ov_trip, fb_disabled, vcc_on,
                 comp_low, ramp_meet, ocp, ac_absent, out_rated);
endinterface
`default_nettype wire

// ### pin_conditioner.sv
`default_nettype none
module pin_conditioner
(
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst,
   // raw comparator levels
   input  wire logic [pfc_pkg::PIN_N-1:0] pins,
   // conditioned levels
   cond_if.prod                           c
);
   import pfc_pkg::*;

   logic [PIN_N-1:0] meta_r;
   logic [PIN_N-1:0] sync_r;
   logic             zc_r;
   logic             ov_r;
   logic             dis_r;
   logic             vcc_r;

   // ---------------------------------------------------------------
   // two-stage synchronisers, one per pin
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < PIN_N; i++)
      begin : g_sync
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               meta_r[i] <= 1'b0;
               sync_r[i] <= 1'b0;
            end
            else
            begin
               meta_r[i] <= pins[i];
               sync_r[i] <= meta_r[i];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // hysteresis latches from threshold pairs
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         zc_r  <= 1'b0;
         ov_r  <= 1'b0;
         dis_r <= 1'b1;   // disabled until feedback proves present
         vcc_r <= 1'b0;
      end
      else
      begin
         if (sync_r[P_ZC_HI])
            zc_r <= 1'b1;
         else if (!sync_r[P_ZC_LO])
            zc_r <= 1'b0;
         if (sync_r[P_FB_OV])
            ov_r <= 1'b1;
         else if (!sync_r[P_FB_OV_REL])
            ov_r <= 1'b0;
         if (!sync_r[P_FB_DIS])
            dis_r <= 1'b1;
         else if (sync_r[P_FB_DIS_REL])
            dis_r <= 1'b0;
         if (sync_r[P_VCC_START])
            vcc_r <= 1'b1;
         else if (!sync_r[P_VCC_STOP])
            vcc_r <= 1'b0;
      end
   end

   // latched and plain levels after synchronisation
   assign c.zc_level    = zc_r;
   assign c.ov_trip     = ov_r;
   assign c.fb_disabled = dis_r;
   assign c.vcc_on      = vcc_r;
   assign c.comp_low    = !sync_r[P_COMP_MIN];
   assign c.ramp_meet   = sync_r[P_RAMP_MEET];
   assign c.ocp         = sync_r[P_CS_LIM];
   assign c.ac_absent   = sync_r[P_AC_ABSENT];
   assign c.out_rated   = sync_r[P_OUT_RATED];
endmodule
`default_nettype wire

// ### boundary_mode_gate_sequencer.sv
`default_nettype none
module boundary_mode_gate_sequencer
#(
   parameter logic [pfc_pkg::CNT_W-1:0] RESTART_CYC =
      pfc_pkg::CNT_W'(pfc_pkg::RESTART_CYC),
   parameter logic [pfc_pkg::CNT_W-1:0] SS_STEP_CYC =
      pfc_pkg::CNT_W'(pfc_pkg::SS_STEP_CYC),
   parameter logic [pfc_pkg::CNT_W-1:0] HO_STEP_CYC =
      pfc_pkg::CNT_W'(pfc_pkg::HO_STEP_CYC)
)
(
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst,
   // comparator inputs from the analog front end
   input  wire logic                       zc_above_hi,
   input  wire logic                       zc_above_lo,
   input  wire logic                       fb_above_ov,
   input  wire logic                       fb_above_ov_rel,
   input  wire logic                       fb_above_dis,
   input  wire logic                       fb_above_dis_rel,
   input  wire logic                       vcc_above_start,
   input  wire logic                       vcc_above_stop,
   input  wire logic                       comp_above_min,
   input  wire logic                       ramp_meets_comp,
   input  wire logic                       cs_above_limit,
   input  wire logic                       ac_absent,
   input  wire logic                       out_rated,
   // gate and loop control
   output logic                            gate,
   output logic                            output_overvoltage_trip,
   output logic                            ocp_trip,
   output logic [pfc_pkg::STEP_W-1:0]      ref_step,
   output logic [pfc_pkg::STEP_W-1:0]      blend_step,
   output logic                            ext_comp_sel,
   // register port
   input  wire logic [pfc_pkg::ADDR_W-1:0] addr,
   input  wire logic [31:0]                wdata,
   input  wire logic                       wr,
   input  wire logic                       rd,
   output logic [31:0]                     rdata
);
   import pfc_pkg::*;

   cond_if c_if ();

   logic [PIN_N-1:0]  pins;
   gate_state_t       gst_r;
   ss_state_t         ss_r;
   logic              zc_prev_r;
   logic [CNT_W-1:0]  off_cnt_r;
   logic [CNT_W-1:0]  blank_cnt_r;
   logic [CNT_W-1:0]  step_cnt_r;
   logic [STEP_W-1:0] ref_step_r;
   logic [STEP_W-1:0] blend_step_r;
   logic [31:0]       ctrl_r;
   logic [31:0]       rdata_r;
   logic              gate_r;
   logic              ov_out_r;
   logic              ocp_out_r;
   logic              ext_r;
   logic              zc_fall;
   logic              blank_done;
   logic              restart_due;
   logic              allowed;
   logic              turn_on;
   logic              turn_off;
   logic              step_tick;
   logic [31:0]       status;

   // ---------------------------------------------------------------
   // input conditioning
   // ---------------------------------------------------------------
   always_comb
   begin
      pins               = '0;
      pins[P_ZC_HI]      = zc_above_hi;
      pins[P_ZC_LO]      = zc_above_lo;
      pins[P_FB_OV]      = fb_above_ov;
      pins[P_FB_OV_REL]  = fb_above_ov_rel;
      pins[P_FB_DIS]     = fb_above_dis;
      pins[P_FB_DIS_REL] = fb_above_dis_rel;
      pins[P_VCC_START]  = vcc_above_start;
      pins[P_VCC_STOP]   = vcc_above_stop;
      pins[P_COMP_MIN]   = comp_above_min;
      pins[P_RAMP_MEET]  = ramp_meets_comp;
      pins[P_CS_LIM]     = cs_above_limit;
      pins[P_AC_ABSENT]  = ac_absent;
      pins[P_OUT_RATED]  = out_rated;
   end

   pin_conditioner u_cond
   (
      .clk  (clk),
      .rst  (rst),
      .pins (pins),
      .c    (c_if.prod)
   );

   // ---------------------------------------------------------------
   // gate permission and turn-on events
   // ---------------------------------------------------------------
   // falling edge of the zero-current level
   assign zc_fall     = zc_prev_r && !c_if.zc_level;
   // edges inside the blanking window are simply lost
   assign blank_done  = (blank_cnt_r >= CNT_W'(BLANK_CYC));
   // off time long enough to force a restart
   assign restart_due = (off_cnt_r >= RESTART_CYC);
   // every gate blocker except over-current in one term
   assign allowed     = c_if.vcc_on && !c_if.ov_trip &&
                        !c_if.fb_disabled && !c_if.comp_low &&
                        (ss_r != SS_IDLE) &&
                        !ctrl_r[CTRL_SW_DISABLE];
   assign turn_on     = allowed && !c_if.ocp &&
                        ((zc_fall && blank_done) || restart_due);
   // ramp match or over-current ends the pulse
   assign turn_off    = c_if.ramp_meet || c_if.ocp || !allowed;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         zc_prev_r <= 1'b0;
      else
         zc_prev_r <= c_if.zc_level;
   end

   // ---------------------------------------------------------------
   // gate state machine
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         gst_r  <= G_OFF;
         gate_r <= 1'b0;
      end
      else
      begin
         unique case (gst_r)
            G_OFF:
               if (turn_on)
               begin
                  gst_r  <= G_ON;
                  gate_r <= 1'b1;
               end
            G_ON:
               // off at once, stays off until next turn-on
               if (turn_off)
               begin
                  gst_r  <= G_OFF;
                  gate_r <= 1'b0;
               end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // off-time restart counter
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         off_cnt_r <= '0;
      else if (gst_r == G_ON || turn_on)
         off_cnt_r <= '0;
      // saturate so an expired timer waits for permission
      else if (!restart_due)
         off_cnt_r <= off_cnt_r + CNT_W'(1);
   end

   // ---------------------------------------------------------------
   // blanking window from the gate rising edge
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         blank_cnt_r <= CNT_W'(BLANK_CYC);   // first start not blanked
      else if (gst_r == G_OFF && turn_on)
         blank_cnt_r <= '0;
      else if (!blank_done)
         blank_cnt_r <= blank_cnt_r + CNT_W'(1);
   end

   // ---------------------------------------------------------------
   // soft-start and compensator hand-over
   // ---------------------------------------------------------------
   always_comb
   begin
      step_tick = 1'b0;
      if (ss_r == SS_RAMP)
         step_tick = (step_cnt_r >= SS_STEP_CYC - CNT_W'(1));
      else if (ss_r == SS_BLEND)
         step_tick = (step_cnt_r >= HO_STEP_CYC - CNT_W'(1));
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ss_r         <= SS_IDLE;
         step_cnt_r   <= '0;
         ref_step_r   <= '0;
         blend_step_r <= '0;
      end
      // lost input or supply restarts the sequence
      else if (!c_if.vcc_on || c_if.ac_absent)
      begin
         ss_r         <= SS_IDLE;
         step_cnt_r   <= '0;
         ref_step_r   <= '0;
         blend_step_r <= '0;
      end
      else
      begin
         step_cnt_r <= step_tick ? '0 : step_cnt_r + CNT_W'(1);
         unique case (ss_r)
            SS_IDLE:
            begin
               ss_r       <= SS_RAMP;
               step_cnt_r <= '0;
            end
            // stair-step reference over the soft-start time
            SS_RAMP:
               if (step_tick)
               begin
                  if (ref_step_r == STEP_MAX)
                     ss_r <= SS_PROP;
                  else
                     ref_step_r <= ref_step_r + STEP_W'(1);
               end
            // proportional loop until output is rated
            SS_PROP:
               if (c_if.out_rated)
               begin
                  ss_r       <= SS_BLEND;
                  step_cnt_r <= '0;
               end
            SS_BLEND:
               if (step_tick)
               begin
                  if (blend_step_r == STEP_MAX)
                     ss_r <= SS_EXT;
                  else
                     blend_step_r <= blend_step_r + STEP_W'(1);
               end
            SS_EXT:
               step_cnt_r <= '0;
            default:
               ss_r <= SS_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // registered status outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ov_out_r  <= 1'b0;
         ocp_out_r <= 1'b0;
         ext_r     <= 1'b0;
      end
      else
      begin
         ov_out_r  <= c_if.ov_trip;
         ocp_out_r <= c_if.ocp;
         ext_r     <= (ss_r == SS_EXT);
      end
   end

   assign gate                    = gate_r;
   assign output_overvoltage_trip = ov_out_r;
   assign ocp_trip                = ocp_out_r;
   assign ref_step                = ref_step_r;
   assign blend_step              = blend_step_r;
   assign ext_comp_sel            = ext_r;

   // ---------------------------------------------------------------
   // register port
   // ---------------------------------------------------------------
   always_comb
   begin
      status              = '0;
      status[ST_GATE]     = gate_r;
      status[ST_VCC_ON]   = c_if.vcc_on;
      status[ST_OV]       = c_if.ov_trip;
      status[ST_FB_DIS]   = c_if.fb_disabled;
      status[ST_OCP]      = c_if.ocp;
      status[ST_COMP_LOW] = c_if.comp_low;
      status[ST_AC_ABS]   = c_if.ac_absent;
      status[ST_EXT_COMP] = ext_r;
   end

   // software disable holds the gate off, like open feedback
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ctrl_r <= CTRL_RESET;
      else if (wr && addr == REG_CTRL)
         ctrl_r <= {31'h00000000, wdata[CTRL_SW_DISABLE]};
   end

   // read data valid in the cycle after the strobe only
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rdata_r <= '0;
      else if (rd)
      begin
         unique case (addr)
            REG_STATUS: rdata_r <= status;
            REG_CTRL:   rdata_r <= ctrl_r;
            REG_STEPS:  rdata_r <= {21'h000000, ss_r,
                                    blend_step_r, ref_step_r};
            default:    rdata_r <= '0;
         endcase
      end
      else
         rdata_r <= '0;
   end

   assign rdata = rdata_r;
endmodule
`default_nettype wire

// ### gate_seq_monitor.sv
`default_nettype none
module gate_seq_monitor
#(
   parameter logic [pfc_pkg::CNT_W-1:0] RESTART_CYC =
      pfc_pkg::CNT_W'(pfc_pkg::RESTART_CYC)
)
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // comparator levels
   input  wire logic       comp_above_min,
   input  wire logic       ramp_meets_comp,
   input  wire logic       cs_above_limit,
   input  wire logic       fb_above_ov,
   input  wire logic       fb_above_dis,
   input  wire logic       vcc_above_stop,
   input  wire logic       ac_absent,
   // design outputs
   input  wire logic       gate,
   input  wire logic       output_overvoltage_trip,
   input  wire logic       ocp_trip,
   input  wire logic [3:0] ref_step,
   input  wire logic [3:0] blend_step,
   input  wire logic       ext_comp_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   import pfc_pkg::*;

   logic             gate_q;
   logic [9:0]       since_rise;
   logic [CNT_W-1:0] off_cnt;

   default clocking mon_cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // edge history; rise distance starts saturated as no blank is pending
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         gate_q     <= 1'b0;
         since_rise <= 10'h3FF;
         off_cnt    <= '0;
      end
      else
      begin
         gate_q     <= gate;
         since_rise <= (gate && !gate_q) ? 10'h000 :
                       since_rise + 10'(since_rise != 10'h3FF);
         off_cnt    <= gate ? '0 : off_cnt + CNT_W'(~&off_cnt);
      end
   end

   // pin paths: 2 sync stages, level stage on hysteresis pins only, gate flop
   a_ramp_ends_on:
      assert property (ramp_meets_comp [*4] |=> !gate)
      else $error("gate on after ramp met error level");
   a_ocp_cuts_gate:
      assert property (cs_above_limit [*3] |=> !gate)
      else $error("gate not cut by over-current");
   a_ocp_level:
      assert property (cs_above_limit [*4] |=> ocp_trip)
      else $error("over-current level missing");
   a_comp_low_stop:
      assert property ((!comp_above_min) [*5] |=> !gate)
      else $error("gate on with low error level");
   a_ov_trip_off:
      assert property (fb_above_ov [*5] |=> output_overvoltage_trip && !gate)
      else $error("overvoltage did not stop gate");
   a_fb_low_off:
      assert property ((!fb_above_dis) [*5] |=> !gate)
      else $error("gate on with feedback low");
   a_supply_off:
      assert property ((!vcc_above_stop) [*5] |=> !gate)
      else $error("gate on with supply low");
   // an early rise is only legal when the restart timer ran out
   a_blank_rise:
      assert property (gate && !gate_q |-> since_rise >= 10'(BLANK_CYC - 1)
                       || off_cnt + 20'h00002 >= RESTART_CYC)
      else $error("gate rose inside blank window");
   a_stair_step:
      assert property ($changed(ref_step) |->
                       ref_step == $past(ref_step) + 4'h1 || ref_step == 4'h0)
      else $error("reference stepped out of order");
   a_ac_reset:
      assert property (ac_absent [*6] |=> ref_step == 4'h0 && !ext_comp_sel)
      else $error("soft-start not reset without input");
   a_handover_end:
      assert property ($rose(ext_comp_sel) |-> $past(blend_step) == 4'hF)
      else $error("compensator taken before blend end");
endmodule

bind boundary_mode_gate_sequencer gate_seq_monitor
#(
   .RESTART_CYC (RESTART_CYC)
)
i_mon
(
   .clk, .rst, .comp_above_min, .ramp_meets_comp, .cs_above_limit,
   .fb_above_ov, .fb_above_dis, .vcc_above_stop, .ac_absent, .gate,
   .output_overvoltage_trip, .ocp_trip, .ref_step, .blend_step,
   .ext_comp_sel
);
`default_nettype wire

// ### switch_partner.sv
`default_nettype none
module switch_partner
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // gate and timing knobs
   input  wire logic       gate,
   input  wire logic [9:0] on_cyc,
   input  wire logic [9:0] off_cyc,
   input  wire logic       mute,
   // comparator levels back to the controller
   output logic            aux_hi,
   output logic            aux_lo,
   output logic            ramp_meet
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [9:0] on_r;
   logic [9:0] off_r;

   // inductor model; mute stands for a winding that never rings
   // aux falls through 1.5 V a cycle before 1.4 V
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         on_r      <= 10'h000;
         off_r     <= 10'h000;
         aux_hi    <= 1'b0;
         aux_lo    <= 1'b0;
         ramp_meet <= 1'b0;
      end
      else
      begin
         on_r      <= gate ? on_r + 10'h001 : 10'h000;
         ramp_meet <= gate && on_r >= on_cyc;
         off_r     <= gate ? off_cyc : off_r - 10'(off_r != 10'h000);
         aux_hi    <= !gate && !mute && off_r > 10'h001;
         aux_lo    <= !gate && !mute && off_r != 10'h000;
      end
   end
endmodule
`default_nettype wire

// ### tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pfc_pkg::*;

   localparam logic [CNT_W-1:0] RST_C  = 20'h00258; // well above blank
   localparam logic [CNT_W-1:0] STEP_C = 20'h00008;
   localparam logic [9:0]       GOOD   = 10'h0F8;   // every level in range
   logic              clk;
   logic              rst;
   logic [9:0]        pins;
   logic              aux_hi, aux_lo, ramp_meet, mute;
   logic [9:0]        on_cyc, off_cyc;
   logic [ADDR_W-1:0] addr;
   logic [31:0]       wdata, rdata, val;
   logic              wr, rd, gate, ov_trip, ocp, ext;
   logic [STEP_W-1:0] ref_step, blend_step;
   int                n_fail, checks_done, hi, lo, n;
   logic [9:0]        mask1 [5] = '{10'h80, 10'h6, 10'h18, 10'h60, 10'h100};
   logic [9:0]        mask2 [5] = '{10'h0, 10'h4, 10'h10, 10'h20, 10'h0};
   boundary_mode_gate_sequencer
   #(
      .RESTART_CYC (RST_C),
      .SS_STEP_CYC (STEP_C),
      .HO_STEP_CYC (STEP_C)
   )
   i_dut
   (
      .clk (clk), .rst (rst), .zc_above_hi (aux_hi), .zc_above_lo (aux_lo),
      .cs_above_limit (pins[0]), .fb_above_ov (pins[1]),
      .fb_above_ov_rel (pins[2]), .fb_above_dis (pins[3]),
      .fb_above_dis_rel (pins[4]), .vcc_above_start (pins[5]),
      .vcc_above_stop (pins[6]), .comp_above_min (pins[7]),
      .ac_absent (pins[8]), .out_rated (pins[9]), .ramp_meets_comp (ramp_meet),
      .gate (gate), .output_overvoltage_trip (ov_trip), .ocp_trip (ocp),
      .ref_step (ref_step), .blend_step (blend_step), .ext_comp_sel (ext),
      .addr (addr), .wdata (wdata), .wr (wr), .rd (rd), .rdata (rdata)
   );

   switch_partner i_sw
   (
      .clk (clk), .rst (rst), .gate (gate), .on_cyc (on_cyc),
      .off_cyc (off_cyc), .mute (mute), .aux_hi (aux_hi), .aux_lo (aux_lo),
      .ramp_meet (ramp_meet)
   );

   // 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [ADDR_W-1:0] a);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(negedge clk);
      val = rdata;
   endtask

   // one full pulse: high time, then low time up to the next rise
   task automatic measure();
      for (n = 0; n < 4000 && gate !== 1'b0; n++) @(negedge clk);
      for (n = 0; n < 4000 && gate !== 1'b1; n++) @(negedge clk);
      for (hi = 0; hi < 4000 && gate === 1'b1; hi++) @(negedge clk);
      for (lo = 0; lo < 4000 && gate === 1'b0; lo++) @(negedge clk);
   endtask

   task automatic wait_step(input logic blend, input logic [3:0] v);
      for (n = 0; n < 3000 && (blend ? blend_step : ref_step) !== v; n++)
         @(negedge clk);
   endtask

   // settle past pin latency, then count gate-high cycles beyond restart time
   task automatic count_gate();
      repeat (8) @(negedge clk);
      n = 0;
      repeat (700) @(negedge clk) n += int'(gate !== 1'b0);
   endtask

   // watchdog, far beyond the expected run of about 15000 cycles
   initial
   begin
      #400000;
      n_fail++;
      results();
   end

   initial
   begin
      rst     = 1'b1;
      pins    = GOOD;
      mute    = 1'b1;
      on_cyc  = 10'h014;
      off_cyc = 10'h190;
      addr    = '0;
      wdata   = '0;
      wr      = 1'b0;
      rd      = 1'b0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      wait_step(1'b0, 4'h1);
      wait_step(1'b0, 4'hF);
      check(n, 14 * STEP_C);
      $display("soft-start test done");
      measure();
      measure();
      check(lo >= RST_C - 1 && lo <= RST_C + 3, 1'b1);
      check(hi > on_cyc && hi <= on_cyc + 8, 1'b1);
      @(posedge clk);
      mute <= 1'b0;
      measure();
      measure();
      check(lo >= off_cyc && lo <= off_cyc + 8, 1'b1);
      @(posedge clk);
      off_cyc <= 10'h014;
      measure();
      measure();
      check(lo >= RST_C - 1, 1'b1);
      $display("turn-on test done");
      @(posedge clk);
      on_cyc <= 10'h12C;
      measure();
      repeat (10) @(posedge clk);
      pins <= GOOD | 10'h001;
      repeat (4) @(negedge clk);
      check(gate, 1'b0);
      check(ocp, 1'b1);
      @(posedge clk);
      pins <= GOOD;
      repeat (8) @(negedge clk);
      check(gate, 1'b0);
      check(ocp, 1'b0);
      $display("over-current test done");
      // second stage keeps only the release level bad: hysteresis must hold
      for (int k = 0; k < 5; k++)
      begin
         @(posedge clk);
         pins <= GOOD ^ mask1[k];
         count_gate();
         check(n, 0);
         if (k == 1) check(ov_trip, 1'b1);
         if (k == 4) check(ref_step, 4'h0);
         if (mask2[k] != 10'h000)
         begin
            @(posedge clk);
            pins <= GOOD ^ mask2[k];
            count_gate();
            check(n, 0);
         end
         @(posedge clk);
         pins <= GOOD;
      end
      wait_step(1'b0, 4'h1);
      check(ref_step, 4'h1);
      $display("blocking test done");
      @(posedge clk);
      pins <= GOOD | 10'h200;
      wait_step(1'b1, 4'h1);
      wait_step(1'b1, 4'hF);
      check(n, 14 * STEP_C);
      for (n = 0; n < 40 && ext !== 1'b1; n++) @(negedge clk);
      check(ext, 1'b1);
      $display("hand-over test done");
      wr_reg(REG_CTRL, 32'h00000001);
      count_gate();
      check(n, 0);
      rd_reg(REG_CTRL);
      check(val, 32'h00000001);
      rd_reg(REG_STATUS);
      check(val[ST_VCC_ON], 1'b1);
      check(val[ST_EXT_COMP], 1'b1);
      rd_reg(REG_STEPS);
      check(val[7:0], 8'hFF);
      rd_reg(4'hC);
      check(val, 32'h00000000);
      wr_reg(REG_CTRL, 32'h00000000);
      count_gate();
      check(n != 0, 1'b1);
      $display("register test done");
      results();
   end
endmodule
`default_nettype wire
